// ### spm_core.sv
// Serial memory command engine with its commit FIFO
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [D-1:0][W-1:0] mem;
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = cnt != (AW+1)'(D);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        mem[wp] <= in_data;
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule : spm_fifo

module spm_core #(
  parameter int unsigned PROG_CYCLES = `SPM_PROG_CYC,
  parameter logic [31:0][7:0] OTP_FACTORY = {32{8'h5A}}
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  output logic write_busy_flag,
  output logic store_unlock_latch
);
  import spm_pkg::*;

  // Factory half of the one-time area; value is arbitrary

  spm_st_s st;
  spm_st_s next_st;
  logic [7:0] mem_arr [0:32767];
  logic mem_we;
  logic [14:0] mem_wa;
  logic [7:0] mem_wd;
  logic rise;
  logic fall;
  logic cs_rise;
  logic cs_fall;
  logic bnd;
  logic [7:0] rx_byte;
  logic push_v;
  logic push_rdy;
  logic [`SPM_FIFO_W-1:0] push_d;
  logic pop_v;
  logic pop_rdy;
  logic [`SPM_FIFO_W-1:0] pop_d;

  function automatic logic [7:0] status_byte(input logic busy, input logic unl);
    logic [7:0] s;
    s = 8'h00;
    s[`SPM_ST_BUSY_BIT] = busy;
    s[`SPM_ST_UNLOCK_BIT] = unl;
    return s;
  endfunction : status_byte

  function automatic logic [7:0] otp_byte(input logic [31:0][7:0] usr, input logic [5:0] i);
    return i[5] ? OTP_FACTORY[i[4:0]] : usr[i[4:0]];
  endfunction : otp_byte

  assign rise = st.sck_s2 && !st.sck_s3 && !st.cs_s2;
  assign fall = !st.sck_s2 && st.sck_s3 && !st.cs_s2;
  assign cs_rise = st.cs_s2 && !st.cs_s3;
  assign cs_fall = !st.cs_s2 && st.cs_s3;
  assign bnd = rise && st.bit_cnt == 3'h7;
  assign rx_byte = {st.rx[6:0], st.sdi_s2};
  assign push_v = st.walking && st.pvalid[st.cmt_idx];
  assign push_d = st.otp_tgt ? {1'b1, 10'h000, st.cmt_idx, st.pbuf[st.cmt_idx]}
                             : {1'b0, st.addr[14:5], st.cmt_idx, st.pbuf[st.cmt_idx]};
  assign pop_rdy = st.div == `SPM_DRAIN_DIV;

  // Commit path: page buffer walker fills, slow write strobe drains
  spm_fifo #(.W(`SPM_FIFO_W), .D(`SPM_FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_d),
    .out_valid(pop_v),
    .out_ready(pop_rdy),
    .out_data(pop_d)
  );

  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_wa = pop_d[22:8];
    mem_wd = pop_d[7:0];
    next_st.sck_s1 = spi_sck;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_s3 = st.sck_s2;
    next_st.cs_s1 = spi_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.sdi_s1 = serial_in_pin;
    next_st.sdi_s2 = st.sdi_s1;
    next_st.div = pop_rdy ? 2'h0 : st.div + 2'h1;
    // Walker pushes only bytes that were received in this command
    if (st.walking && (!push_v || push_rdy)) begin // see [R14]
      next_st.cmt_idx = st.cmt_idx + 5'h01;
      if (st.cmt_idx == 5'h1F) begin
        next_st.walking = 1'b0;
      end
    end
    if (pop_v && pop_rdy) begin
      if (pop_d[`SPM_FIFO_OTP_BIT]) begin
        next_st.otp_user[pop_d[12:8]] = pop_d[7:0]; // see [R17]
      end else begin
        mem_we = 1'b1;
      end
    end
    if (st.busy && st.timer != 17'h00000) begin
      next_st.timer = st.timer - 17'h00001;
    end
    if (st.busy && st.timer == 17'h00000 && !st.walking && !pop_v) begin
      next_st.busy = 1'b0;
      next_st.unlock = 1'b0; // see [R15]
      if (st.otp_tgt) begin
        next_st.otp_locked = 1'b1; // see [R20]
      end
    end
    if (cs_fall) begin
      next_st.state = SPM_CMD;
      next_st.bit_cnt = 3'h0;
    end else if (rise) begin
      next_st.rx = rx_byte; // see [R27]
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == 3'h7) begin
        case (st.state)
          SPM_CMD: begin
            next_st.cmd = rx_byte;
            if (st.busy && rx_byte != `SPM_OP_STATUS) begin
              next_st.state = SPM_IGNORE; // see [R10]
            end else begin
              case (rx_byte)
                `SPM_OP_READ, `SPM_OP_QUICK_FETCH_COMMAND, `SPM_OP_OTP_READ: begin
                  next_st.state = SPM_ADDR1;
                end
                `SPM_OP_STORE: begin
                  next_st.state = st.unlock ? SPM_ADDR1 : SPM_IGNORE; // see [R16]
                end
                `SPM_OP_OTP_PROG: begin
                  next_st.state = st.otp_locked ? SPM_IGNORE : SPM_ADDR1; // see [R20]
                end
                `SPM_OP_STATUS: begin
                  next_st.state = SPM_STREAM; // see [R26]
                  next_st.src = SPM_SRC_STATUS;
                  next_st.tx = status_byte(st.busy, st.unlock); // see [R11]
                end
                `SPM_OP_UNLOCK: begin
                  next_st.state = SPM_UNLOCK;
                end
                default: begin
                  next_st.state = SPM_IGNORE;
                end
              endcase
            end
          end
          SPM_ADDR1: begin
            next_st.addr[14:8] = rx_byte[6:0];
            next_st.hi_ok = rx_byte == 8'h00;
            next_st.state = SPM_ADDR2;
          end
          SPM_ADDR2: begin
            next_st.addr[7:0] = rx_byte;
            case (st.cmd)
              `SPM_OP_READ: begin
                next_st.state = SPM_STREAM; // see [R1]
                next_st.src = SPM_SRC_MEM;
                next_st.tx = mem_arr[{st.addr[14:8], rx_byte}];
                next_st.addr = {st.addr[14:8], rx_byte} + 15'h0001;
              end
              `SPM_OP_QUICK_FETCH_COMMAND: begin
                next_st.state = SPM_DUMMY; // see [R6]
              end
              `SPM_OP_STORE: begin
                next_st.state = SPM_STORE;
                next_st.in_idx = rx_byte[4:0];
                next_st.pvalid = 32'h00000000;
                next_st.got = 1'b0;
                next_st.otp_tgt = 1'b0;
              end
              `SPM_OP_OTP_PROG: begin
                // Page buffer is reused; its valid flags are cleared here
                next_st.state = (st.hi_ok && rx_byte == 8'h00) ? SPM_STORE : SPM_IGNORE; // see [R18] see [R21]
                next_st.in_idx = 5'h00;
                next_st.pvalid = 32'h00000000;
                next_st.got = 1'b0;
                next_st.otp_tgt = 1'b1;
              end
              `SPM_OP_OTP_READ: begin
                next_st.state = (st.hi_ok && rx_byte == 8'h00) ? SPM_STREAM : SPM_IGNORE; // see [R22]
                next_st.src = SPM_SRC_OTP;
                next_st.tx = otp_byte(st.otp_user, 6'h00);
                next_st.otp_idx = 6'h01;
              end
              default: begin
                next_st.state = SPM_IGNORE;
              end
            endcase
          end
          SPM_DUMMY: begin
            next_st.state = SPM_STREAM; // see [R6]
            next_st.src = SPM_SRC_MEM;
            next_st.tx = mem_arr[st.addr];
            next_st.addr = st.addr + 15'h0001;
          end
          SPM_STREAM: begin
            // Input bits are not decoded while streaming
            case (st.src)
              SPM_SRC_MEM: begin
                next_st.tx = mem_arr[st.addr]; // see [R3]
                next_st.addr = st.addr + 15'h0001; // see [R4] see [R5]
              end
              SPM_SRC_STATUS: begin
                next_st.tx = status_byte(st.busy, st.unlock); // see [R26]
              end
              SPM_SRC_OTP: begin
                next_st.tx = otp_byte(st.otp_user, st.otp_idx); // see [R22]
                next_st.otp_idx = st.otp_idx + 6'h01;
              end
              default: begin
                next_st.tx = 8'h00;
              end
            endcase
          end
          SPM_STORE: begin
            next_st.pbuf[st.in_idx] = rx_byte; // see [R13]
            next_st.pvalid[st.in_idx] = 1'b1;
            next_st.in_idx = st.in_idx + 5'h01; // see [R12] see [R19]
            next_st.got = 1'b1;
          end
          default: begin
            next_st.state = st.state;
          end
        endcase
      end
    end else if (fall) begin
      if (st.state == SPM_STREAM) begin
        next_st.dout = st.tx[7]; // see [R27]
        next_st.tx = {st.tx[6:0], 1'b0};
        next_st.oe_n = 1'b0;
      end
    end else if (cs_rise) begin
      next_st.oe_n = 1'b1; // see [R23]
      next_st.state = SPM_CMD;
      if (st.bit_cnt == 3'h0) begin // see [R25]
        if (st.state == SPM_UNLOCK) begin
          next_st.unlock = 1'b1; // see [R24]
        end
        if (st.state == SPM_STORE && st.got) begin
          next_st.busy = 1'b1; // see [R9] see [R18]
          next_st.timer = 17'(PROG_CYCLES);
          next_st.walking = 1'b1;
          next_st.cmt_idx = 5'h00;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_s3 <= 1'b1;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem_arr[mem_wa] <= mem_wd;
    end
  end

  assign serial_out_pin = st.dout;
  assign serial_out_oe_n = st.oe_n;
  assign write_busy_flag = st.busy;
  assign store_unlock_latch = st.unlock;

  sequence s_cs_rise;
    st.cs_s2 && !st.cs_s3;
  endsequence

  sequence s_whole;
    st.bit_cnt == 3'h0;
  endsequence

  chk_hiz_deselect: assert property (@(posedge ref_clk) disable iff (rst) // see [R23]
    s_cs_rise |=> serial_out_oe_n [*2])
    else $error("output not released after deselect");
  chk_unlock_set: assert property (@(posedge ref_clk) disable iff (rst) // see [R24]
    s_cs_rise ##0 s_whole ##0 (st.state == SPM_UNLOCK) |=> store_unlock_latch)
    else $error("unlock latch not set");
  chk_partial_keep: assert property (@(posedge ref_clk) disable iff (rst) // see [R25]
    s_cs_rise ##0 (st.bit_cnt != 3'h0 && !st.busy) |=> $stable(store_unlock_latch) && !$rose(write_busy_flag))
    else $error("partial byte executed");
  chk_store_start: assert property (@(posedge ref_clk) disable iff (rst) // see [R9]
    s_cs_rise ##0 s_whole ##0 (st.state == SPM_STORE && st.got) |=> write_busy_flag ##1 write_busy_flag)
    else $error("write cycle not started");
  chk_store_locked: assert property (@(posedge ref_clk) disable iff (rst) // see [R16]
    bnd && st.state == SPM_CMD && rx_byte == `SPM_OP_STORE && !st.unlock |=> st.state == SPM_IGNORE)
    else $error("store accepted without unlock");
  chk_busy_clear: assert property (@(posedge ref_clk) disable iff (rst) // see [R15]
    $fell(write_busy_flag) |-> !store_unlock_latch)
    else $error("unlock latch kept after write");
  chk_status_bit: assert property (@(posedge ref_clk) disable iff (rst) // see [R11]
    bnd && st.state == SPM_CMD && rx_byte == `SPM_OP_STATUS
    |=> st.tx[`SPM_ST_BUSY_BIT] == $past(st.busy) && st.tx[`SPM_ST_UNLOCK_BIT] == $past(st.unlock))
    else $error("status byte wrong");
  chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (rst) // see [R10]
    bnd && st.state == SPM_CMD && st.busy && rx_byte != `SPM_OP_STATUS |=> st.state == SPM_IGNORE)
    else $error("command accepted while busy");
  chk_read_incr: assert property (@(posedge ref_clk) disable iff (rst) // see [R4]
    bnd && st.state == SPM_STREAM && st.src == SPM_SRC_MEM |=> st.addr == 15'($past(st.addr) + 15'h0001))
    else $error("read address not advanced");
  chk_page_hold: assert property (@(posedge ref_clk) disable iff (rst) // see [R12]
    bnd && st.state == SPM_STORE |=> st.in_idx == 5'($past(st.in_idx) + 5'h01) && $stable(st.addr))
    else $error("page position wrong");
  chk_otp_lock: assert property (@(posedge ref_clk) disable iff (rst) // see [R20]
    st.otp_locked |=> st.otp_locked)
    else $error("one-time lock lost");
  chk_otp_refuse: assert property (@(posedge ref_clk) disable iff (rst) // see [R20]
    bnd && st.state == SPM_CMD && rx_byte == `SPM_OP_OTP_PROG && st.otp_locked |=> st.state == SPM_IGNORE)
    else $error("one-time area reprogrammed");
endmodule : spm_core

// ### spm_cfg.svh
// Constants of the serial memory command engine
// Function
// [R1] Opcode 03h then sixteen address bits starts a read; data follows on output.
// [R2] Host sends both address bytes and drives the unused top bit to zero.
// [R3] After read opcode and address, further input bits are disregarded.
// [R4] Reads increment the byte address after each output byte while selected.
// [R5] Read address counter wraps from the highest address to zero.
// [R6] Opcode 0Bh takes two address bytes and one dummy byte before data.
// [R7] Host raises chip select after the last wanted byte; that ends a read.
// [R8] Host issues store-unlock and ends it before starting a store (02h).
// [R9] Chip select rising after a whole data byte starts the self-timed write.
// [R10] While writing internally, every command except status fetch is ignored.
// [R11] Status bit 0 reads one while the write cycle runs, zero after.
// [R12] Store increments only in-page address bits; data wraps within the 32-byte page.
// [R13] Beyond 32 store bytes, earlier bytes are discarded; final 32 are written.
// [R14] Short stores write only addressed bytes; rest of page unchanged.
// [R15] Every program cycle ends by clearing the store-unlock latch.
// [R16] Store without prior unlock is ignored until the next selection.
// [R17] One-time area: 64 bytes, 0-31 user, 32-63 fixed factory data.
// [R18] Opcodes 9Bh 00h 00h plus data program the user area; busy shows meanwhile.
// [R19] Extra one-time data wraps the write position back to location zero.
// [R20] Once programmed, the user one-time area refuses further programming.
// [R21] One-time programming reuses and overwrites the page buffer.
// [R22] Opcode 77h 00h 00h streams the one-time area; beyond its end undefined.
// [R23] Deselect ends the one-time read and releases the output pin.
// [R24] Opcode 06h sets the store-unlock latch when chip select rises.
// [R25] Chip select rising mid-byte executes nothing; unlock latch unchanged.
// [R26] Opcode 05h returns status with busy flag and unlock latch.
// [R27] Input sampled on rising, output changed on falling clock; MSB first.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_OP_READ 8'h03
`define SPM_OP_QUICK_FETCH_COMMAND 8'h0B
`define SPM_OP_STORE 8'h02
`define SPM_OP_UNLOCK 8'h06
`define SPM_OP_STATUS 8'h05
`define SPM_OP_OTP_PROG 8'h9B
`define SPM_OP_OTP_READ 8'h77
`define SPM_ST_BUSY_BIT 0
`define SPM_ST_UNLOCK_BIT 1
`define SPM_CLK_NS 20
`define SPM_T_PROG_NS 1000000
`define SPM_PROG_CYC ((`SPM_T_PROG_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_DRAIN_DIV 2'h3
`define SPM_FIFO_W 24
`define SPM_FIFO_DEPTH 8
`define SPM_FIFO_OTP_BIT 23
`endif

// ### spm_pkg.sv
// Types of the serial memory command engine
package spm_pkg;
  typedef enum logic [2:0] {
    SPM_CMD,
    SPM_ADDR1,
    SPM_ADDR2,
    SPM_DUMMY,
    SPM_STREAM,
    SPM_STORE,
    SPM_UNLOCK,
    SPM_IGNORE
  } spm_state_e;

  typedef enum logic [1:0] {
    SPM_SRC_MEM,
    SPM_SRC_STATUS,
    SPM_SRC_OTP
  } spm_src_e;

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sdi_s1;
    logic sdi_s2;
    spm_state_e state;
    spm_src_e src;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] cmd;
    logic hi_ok;
    logic [14:0] addr;
    logic [4:0] in_idx;
    logic got;
    logic [5:0] otp_idx;
    logic [7:0] tx;
    logic dout;
    logic oe_n;
    logic unlock;
    logic busy;
    logic otp_tgt;
    logic otp_locked;
    logic [16:0] timer;
    logic walking;
    logic [4:0] cmt_idx;
    logic [1:0] div;
    logic [31:0] pvalid;
    logic [31:0][7:0] pbuf;
    logic [31:0][7:0] otp_user;
  } spm_st_s;
endpackage : spm_pkg

// ### spm_host.sv
// SPI host model that drives the serial memory pins
`timescale 1ns/1ps

module spm_host #(
  parameter int H = 6
) (
  input wire logic ref_clk,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    serial_in_pin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic sel();
    spi_cs_n = 1'b0;
    tick(H);
  endtask : sel

  // Raise select in the low phase right after the last bit
  task automatic desel();
    tick(2);
    spi_cs_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    tick(H);
  endtask : desel

  // Mode 0, most significant bit first; a released output reads unknown
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serial_in_pin = tx[i];
      tick(H);
      spi_sck = 1'b1;
      rx[i] = serial_out_oe_n ? 1'bx : serial_out_pin;
      tick(H);
      spi_sck = 1'b0;
    end
  endtask : bits
endmodule : spm_host

// ### tb.sv
// Self-checking bench of the serial memory command engine
`timescale 1ns/1ps

module tb;
  import spm_pkg::*;
  typedef struct {logic [15:0] a; int n; logic [7:0] b; logic f;} spm_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic spi_sck;
  logic spi_cs_n;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe_n;
  logic write_busy_flag;
  logic store_unlock_latch;
  int errors = 0;
  int n_checks = 0;
  logic [7:0] mem [int];
  logic [7:0] otp [32];
  logic [7:0] rx [$];
  logic [7:0] q [$];
  logic [7:0] r;
  spm_row_s rows [4] = '{'{16'h0100, 32, 8'h10, 1'b0}, '{16'h0105, 1, 8'hA0, 1'b1},
                         '{16'h011E, 4, 8'hC0, 1'b0}, '{16'h0200, 34, 8'h40, 1'b1}};

  always #10 ref_clk = ~ref_clk;

  spm_core #(.PROG_CYCLES(2000)) i_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n),
    .write_busy_flag(write_busy_flag),
    .store_unlock_latch(store_unlock_latch)
  );

  spm_host i_host (
    .ref_clk(ref_clk),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n)
  );

  function automatic logic [7:0] b8(input logic v);
    return {7'h00, v};
  endfunction : b8

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // One selected session, one received byte per byte sent
  task automatic run(input logic [7:0] tx [$]);
    logic [7:0] b;
    rx = {};
    i_host.sel();
    foreach (tx[i]) begin
      i_host.bits(tx[i], 8, b);
      rx.push_back(b);
    end
    i_host.desel();
  endtask : run

  task automatic wait_idle();
    int k;
    k = 0;
    while (write_busy_flag !== 1'b0 && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    if (k == 5000) begin
      errors++;
      close_out();
    end
  endtask : wait_idle

  task automatic store(input logic [15:0] a, input int n, input logic [7:0] b, input logic en);
    logic [7:0] s [$];
    if (en) run({8'h06});
    s = {8'h02, 8'(a[14:8]), a[7:0]};
    for (int i = 0; i < n; i++) begin
      s.push_back(b + 8'(i));
      if (en) mem[{a[14:5], 5'(a[4:0] + i)}] = b + 8'(i);
    end
    run(s);
    wait_idle();
  endtask : store

  task automatic fetch(input logic [15:0] a, input int n, input logic f);
    logic [7:0] s [$];
    s = {f ? 8'h0B : 8'h03, 8'(a[14:8]), a[7:0]};
    if (f) s.push_back(8'h00);
    repeat (n) s.push_back(8'hFF);
    run(s);
    repeat (f ? 4 : 3) void'(rx.pop_front());
  endtask : fetch

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    i_host.tick(3);
    check("oe_n", b8(serial_out_oe_n), 8'h01);
    check("busy", b8(write_busy_flag), 8'h00);
    check("latch", b8(store_unlock_latch), 8'h00);
    $display("reset test done");
    foreach (rows[k]) begin
      store(rows[k].a, rows[k].n, rows[k].b, 1'b1);
      check("latch", b8(store_unlock_latch), 8'h00);
      fetch({rows[k].a[15:5], 5'h00}, 32, rows[k].f);
      for (int i = 0; i < 32; i++) check("page", rx[i], mem[{rows[k].a[14:5], 5'(i)}]);
      $display("row %0d done", k);
    end
    i_host.sel();
    i_host.bits(8'h06, 5, r);
    i_host.desel();
    check("latch", b8(store_unlock_latch), 8'h00);
    store(16'h0101, 1, 8'hEE, 1'b0);
    fetch(16'h0101, 1, 1'b0);
    check("locked", rx[0], mem[16'h0101]);
    run({8'h06});
    check("latch", b8(store_unlock_latch), 8'h01);
    run({8'h05, 8'hFF, 8'hFF});
    check("status", rx[1], 8'h02);
    check("status", rx[2], 8'h02);
    $display("unlock test done");
    run({8'h02, 8'h03, 8'h00, 8'h77});
    check("busy", b8(write_busy_flag), 8'h01);
    run({8'h05, 8'hFF});
    check("status", rx[1], 8'h03);
    fetch(16'h0100, 1, 1'b0);
    check("refused", rx[0], 8'hxx);
    run({8'h06});
    wait_idle();
    check("latch", b8(store_unlock_latch), 8'h00);
    run({8'h05, 8'hFF});
    check("status", rx[1], 8'h00);
    fetch(16'h0300, 1, 1'b0);
    check("byte", rx[0], 8'h77);
    $display("busy test done");
    store(16'h7FFF, 1, 8'h99, 1'b1);
    store(16'h0000, 1, 8'h11, 1'b1);
    fetch(16'h7FFF, 2, 1'b1);
    check("wrap", rx[0], 8'h99);
    check("wrap", rx[1], 8'h11);
    $display("wrap test done");
    run({8'h9B, 8'h01, 8'h00, 8'h11});
    check("busy", b8(write_busy_flag), 8'h00);
    run({8'h77, 8'h00, 8'h01, 8'hFF});
    check("otp_args", rx[3], 8'hxx);
    $display("argument test done");
    for (int p = 0; p < 2; p++) begin
      run({8'h06});
      q = {8'h9B, 8'h00, 8'h00};
      for (int i = 0; i < 34; i++) begin
        q.push_back(8'(8'h20 + p * 8'h40 + i));
        if (p == 0) otp[i % 32] = 8'(8'h20 + i);
      end
      run(q);
      check("busy", b8(write_busy_flag), b8(p == 0));
      wait_idle();
      if (p == 0) check("latch", b8(store_unlock_latch), 8'h00);
      q = {8'h77, 8'h00, 8'h00};
      repeat (64) q.push_back(8'hFF);
      run(q);
      for (int i = 0; i < 64; i++) check("otp", rx[i + 3], i < 32 ? otp[i] : 8'h5A);
      check("oe_n", b8(serial_out_oe_n), 8'h01);
      $display("otp pass %0d done", p);
    end
    run({8'h06});
    @(posedge ref_clk);
    #1 rst = 1'b1;
    i_host.tick(3);
    rst = 1'b0;
    i_host.tick(3);
    check("latch", b8(store_unlock_latch), 8'h00);
    check("oe_n", b8(serial_out_oe_n), 8'h01);
    $display("mid reset test done");
    close_out();
  end
endmodule : tb
